// ==== dv/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [15:0] src [4] = '{default: 16'h0};
    logic [6:0] p_req = 7'h00;
    logic [6:0] p_en = 7'h00;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] en_o [4];
    logic [15:0] pend [4];
    logic [15:0] prio0, prio1;
    logic [6:0] p_pend;
    int fails = 0;
    int comparisons = 0;

    always #5 mclk = ~mclk;

    iepb_top u_dut (
        .MCLK(mclk), .NRST(nrst),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .SRC_REQ2(src[0]), .SRC_REQ3(src[1]),
        .SRC_REQ4(src[2]), .SRC_REQ5(src[3]), .PRIO_SRC_REQ(p_req),
        .PRIO_SRC_EN(p_en), .EN2(en_o[0]), .EN3(en_o[1]), .EN4(en_o[2]),
        .EN5(en_o[3]), .PRIO0(prio0), .PRIO1(prio1), .PEND2(pend[0]),
        .PEND3(pend[1]), .PEND4(pend[2]), .PEND5(pend[3]),
        .PEND_PRIO(p_pend), .IRQ(irq)
    );

    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        logic aw_r, w_r, b_r;
        logic [1:0] resp;
        b_r = 1'b0;
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= {24'h0, a};
        wvalid <= 1'b1;
        wdata <= {16'h0, d};
        wstrb <= 4'h3;
        bready <= 1'b1;
        while (!b_r) begin
            @(negedge mclk);
            aw_r = awready;
            w_r = wready;
            b_r = bvalid;
            resp = bresp;
            @(posedge mclk);
            if (aw_r) awvalid <= 1'b0;
            if (w_r) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        check("write response", {30'h0, er}, {30'h0, resp});
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar_r, r_r;
        r_r = 1'b0;
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= {24'h0, a};
        rready <= 1'b1;
        while (!r_r) begin
            @(negedge mclk);
            ar_r = arready;
            r_r = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge mclk);
            if (ar_r) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check("read data", {16'h0, exp}, d);
        check("read response", 32'h0, {30'h0, r});
    endtask : rdchk

    ////////////////////////////////////////////////////////////
    task automatic reset_values();
        for (int g = 0; g < 4; g++) begin
            rdchk(8'(g * 4), 16'h0);
        end
        rdchk(8'h10, 16'h4444);
        rdchk(8'h14, 16'h4440);
    endtask : reset_values

    task automatic group_sources();
        logic [15:0] m [4] = '{16'h3fe3, 16'h4066, 16'h210e, 16'h3fbe};
        for (int g = 0; g < 4; g++) begin
            wr(8'(g * 4), 16'hffff, 2'b00);
            rdchk(8'(g * 4), m[g]);
            check("enable out", {16'h0, m[g]}, {16'h0, en_o[g]});
            @(posedge mclk);
            src[g] <= 16'hffff;
            @(posedge mclk);
            src[g] <= 16'h0;
            @(negedge mclk);
            check("pending", {16'h0, m[g]}, {16'h0, pend[g]});
            check("irq", 32'h1, {31'h0, irq});
            wr(8'(g * 4), 16'h5555, 2'b00);
            check("partial", {16'h0, m[g] & 16'h5555}, {16'h0, pend[g]});
            wr(8'(g * 4), 16'h0, 2'b00);
            check("masked", 32'h0, {pend[g], 15'h0, irq});
            rdchk(8'(8'h18 + g * 4), m[g]);
            wr(8'(8'h18 + g * 4), 16'hffff, 2'b00);
            rdchk(8'(8'h18 + g * 4), 16'h0);
        end
    endtask : group_sources

    task automatic priority_codes();
        wr(8'h10, 16'hffff, 2'b00);
        rdchk(8'h10, 16'h7777);
        wr(8'h14, 16'hffff, 2'b00);
        rdchk(8'h14, 16'h7770);
        check("prio out", 32'h77777770, {prio0, prio1});
        @(posedge mclk);
        p_en <= 7'h7f;
        p_req <= 7'h7f;
        @(posedge mclk);
        p_req <= 7'h00;
        @(negedge mclk);
        check("prio pending", 32'h7f, {25'h0, p_pend});
        for (int c = 0; c < 8; c++) begin
            wr(8'h10, 16'h7770 | 16'(c), 2'b00);
            check("pin0 level", 32'(c), {29'h0, prio0[2:0]});
            check("pin0 pending", 32'(c != 0), {31'h0, p_pend[0]});
        end
        for (int i = 0; i < 7; i++) begin
            wr((i < 4) ? 8'h10 : 8'h14, (i < 4) ? ~(16'h7 << (i * 4)) : 16'h7770
                & ~(16'h7 << ((i - 3) * 4)), 2'b00);
            check("field place", 32'(7'h7f & ~(7'h1 << i)), {25'h0, p_pend});
            wr((i < 4) ? 8'h10 : 8'h14, 16'hffff, 2'b00);
        end
        @(posedge mclk);
        p_en <= 7'h00;
        @(negedge mclk);
        check("prio masked", 32'h0, {25'h0, p_pend});
        rdchk(8'h28, 16'h007f);
        wr(8'h28, 16'h007f, 2'b00);
        rdchk(8'h28, 16'h0);
        check("irq idle", 32'h0, {31'h0, irq});
    endtask : priority_codes

    task automatic unmapped();
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h2c, 16'hffff, 2'b10);
        rd(8'h2c, d, r);
        check("unmapped data", 32'h0, d);
        check("unmapped resp", 32'h2, {30'h0, r});
    endtask : unmapped

    ////////////////////////////////////////////////////////////
    task automatic conclude();
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        reset_values();
        group_sources();
        priority_codes();
        unmapped();
        conclude();
    end

    // Run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        conclude();
    end
endmodule : testbench

// ==== rtl/iepb_axil.sv ====
`timescale 1ns/100ps
module iepb_axil (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);

    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    assign awready = !aw_held_r && !bvalid_r;
    assign wready = !w_held_r && !bvalid_r;
    assign arready = !rvalid_r;
    assign wr_en = aw_held_r && w_held_r;
    assign wr_addr = aw_addr_r;
    assign wr_data = w_data_r;
    assign wr_strb = w_strb_r;
    assign rd_addr = araddr[7:0];
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    ////////////////////////////////////////////////////////////////////////////
    // Write address and data, taken in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (awvalid && awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= awaddr[7:0];
        end else if (wr_en) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (wvalid && wready) begin
            w_held_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
        end else if (wr_en) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= iepb_pkg::RESP_OKAY;
        end else if (wr_en) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? iepb_pkg::RESP_OKAY : iepb_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel, data captured at address handshake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= iepb_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_data;
            rresp_r <= rd_ok ? iepb_pkg::RESP_OKAY : iepb_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : iepb_axil

// ==== rtl/iepb_gate.sv ====
`timescale 1ns/100ps
module iepb_gate #(
    parameter int W = 16,
    parameter logic [W-1:0] IMPL = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] req,
    input wire logic [W-1:0] clr,
    input wire logic [W-1:0] en,
    input wire logic [W-1:0] prio_ok,
    output logic [W-1:0] flag,
    output logic [W-1:0] pend
);

    logic [W-1:0] flag_r;

    // Sticky flag; a new request wins over a clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= '0;
        end else begin
            flag_r <= ((flag_r & ~clr) | req) & IMPL; // RQ15
        end
    end

    assign flag = flag_r;
    assign pend = flag_r & en & prio_ok; // RQ1 RQ16

endmodule : iepb_gate

// ==== rtl/iepb_pkg.sv ====
// Behaviour
// RQ1: An enable bit set to 1 passes its source request; 0 blocks it.
// RQ2: Unimplemented enable and priority bits ignore writes and read zero.
// RQ3: Enable group 2 bits 13..5 serve parallel port, compare 8..5, capture 6..3.
// RQ4: Enable group 2 bits 1,0 serve serial-peripheral 2 event and fault; 4..2 absent.
// RQ5: Enable group 3: bit 14 calendar, bits 6,5 pins 4,3, bits 2,1 two-wire 2.
// RQ6: Enable group 4: bit 13 charge time, 8 low voltage, 3 checksum, 2,1 errors.
// RQ7: Enable group 5 bits 13..10: capture 9, compare 9, serial-peripheral 3 sources.
// RQ8: Enable group 5 bits 9..7 port 4, 5,4 two-wire 3, 3..1 port 3.
// RQ9: Priority fields are three bits; code 111 means level 7, the highest.
// RQ10: Code 001 is level 1, the lowest; codes between map linearly.
// RQ11: Priority code 000 disables the source regardless of its enable bit.
// RQ12: Priority group 0: timer1 14..12, compare1 10..8, capture1 6..4, pin0 2..0.
// RQ13: Priority group 1: timer2 14..12, compare2 10..8, capture2 6..4; 3..0 absent.
// RQ14: Software enabling a pin interrupt must also route that pin to a remappable input.
// RQ15: A source flag reads 1 once its request occurred, else 0.
// RQ16: A source is pending only with flag set, enable 1 and priority nonzero.
package iepb_pkg;

    localparam logic [7:0] OFS_EN2 = 8'h00;
    localparam logic [7:0] OFS_EN3 = 8'h04;
    localparam logic [7:0] OFS_EN4 = 8'h08;
    localparam logic [7:0] OFS_EN5 = 8'h0c;
    localparam logic [7:0] OFS_PRIO0 = 8'h10;
    localparam logic [7:0] OFS_PRIO1 = 8'h14;
    localparam logic [7:0] OFS_FLAG2 = 8'h18;
    localparam logic [7:0] OFS_FLAG3 = 8'h1c;
    localparam logic [7:0] OFS_FLAG4 = 8'h20;
    localparam logic [7:0] OFS_FLAG5 = 8'h24;
    localparam logic [7:0] OFS_FLAGP = 8'h28;

    // Implemented bit masks
    localparam logic [15:0] MASK_EN2 = 16'h3fe3; // RQ3 RQ4
    localparam logic [15:0] MASK_EN3 = 16'h4066; // RQ5
    localparam logic [15:0] MASK_EN4 = 16'h210e; // RQ6
    localparam logic [15:0] MASK_EN5 = 16'h3fbe; // RQ7 RQ8
    localparam logic [15:0] MASK_PRIO0 = 16'h7777; // RQ12
    localparam logic [15:0] MASK_PRIO1 = 16'h7770; // RQ13
    localparam logic [6:0] MASK_FLAGP = 7'h7f;

    localparam logic [15:0] RST_EN = 16'h0000;
    localparam logic [15:0] RST_PRIO0 = 16'h4444;
    localparam logic [15:0] RST_PRIO1 = 16'h4440;

    // Priority field positions (low bit of each 3-bit field)
    localparam int FLD_PIN0 = 0;
    localparam int FLD_CAPT = 4;
    localparam int FLD_COMP = 8;
    localparam int FLD_TIMER = 12;
    localparam int FLD_W = 3;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : iepb_pkg

// ==== rtl/iepb_top.sv ====
`timescale 1ns/100ps
module iepb_top (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire logic [15:0] SRC_REQ2,
    input wire logic [15:0] SRC_REQ3,
    input wire logic [15:0] SRC_REQ4,
    input wire logic [15:0] SRC_REQ5,
    input wire logic [6:0] PRIO_SRC_REQ,
    input wire logic [6:0] PRIO_SRC_EN,
    output logic [15:0] EN2,
    output logic [15:0] EN3,
    output logic [15:0] EN4,
    output logic [15:0] EN5,
    output logic [15:0] PRIO0,
    output logic [15:0] PRIO1,
    output logic [15:0] PEND2,
    output logic [15:0] PEND3,
    output logic [15:0] PEND4,
    output logic [15:0] PEND5,
    output logic [6:0] PEND_PRIO,
    output logic IRQ
);

    logic [15:0] en2_r;
    logic [15:0] en3_r;
    logic [15:0] en4_r;
    logic [15:0] en5_r;
    logic [15:0] prio0_r;
    logic [15:0] prio1_r;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [15:0] flag2;
    logic [15:0] flag3;
    logic [15:0] flag4;
    logic [15:0] flag5;
    logic [6:0] flagp;
    logic [6:0] prio_lvl_ok;
    logic [15:0] clr2;
    logic [15:0] clr3;
    logic [15:0] clr4;
    logic [15:0] clr5;
    logic [15:0] clrp;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
        logic [15:0] v;
        v = old;
        if (s[0]) begin
            v[7:0] = d[7:0];
        end
        if (s[1]) begin
            v[15:8] = d[15:8];
        end
        return v & m; // RQ2
    endfunction : merge

    function automatic logic [15:0] ones_hit(input logic [31:0] d, input logic [3:0] s);
        return d[15:0] & {{8{s[1]}}, {8{s[0]}}};
    endfunction : ones_hit

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    function automatic logic [2:0] field(input logic [15:0] r, input int lsb);
        return r[lsb +: iepb_pkg::FLD_W];
    endfunction : field

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave
    iepb_axil u_axil (
        .clk(MCLK),
        .rst_n(NRST),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .awaddr(S_AXI_AWADDR),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .bresp(S_AXI_BRESP),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .araddr(S_AXI_ARADDR),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    always_comb begin
        wr_ok = 1'b1;
        unique case (wr_addr)
            iepb_pkg::OFS_EN2, iepb_pkg::OFS_EN3, iepb_pkg::OFS_EN4, iepb_pkg::OFS_EN5,
            iepb_pkg::OFS_PRIO0, iepb_pkg::OFS_PRIO1, iepb_pkg::OFS_FLAG2,
            iepb_pkg::OFS_FLAG3, iepb_pkg::OFS_FLAG4, iepb_pkg::OFS_FLAG5,
            iepb_pkg::OFS_FLAGP: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_comb begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        unique case (rd_addr)
            iepb_pkg::OFS_EN2: rd_data = {16'h0000, en2_r};
            iepb_pkg::OFS_EN3: rd_data = {16'h0000, en3_r};
            iepb_pkg::OFS_EN4: rd_data = {16'h0000, en4_r};
            iepb_pkg::OFS_EN5: rd_data = {16'h0000, en5_r};
            iepb_pkg::OFS_PRIO0: rd_data = {16'h0000, prio0_r};
            iepb_pkg::OFS_PRIO1: rd_data = {16'h0000, prio1_r};
            iepb_pkg::OFS_FLAG2: rd_data = {16'h0000, flag2};
            iepb_pkg::OFS_FLAG3: rd_data = {16'h0000, flag3};
            iepb_pkg::OFS_FLAG4: rd_data = {16'h0000, flag4};
            iepb_pkg::OFS_FLAG5: rd_data = {16'h0000, flag5};
            iepb_pkg::OFS_FLAGP: rd_data = {25'h0000000, flagp};
            default: rd_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable registers
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            en2_r <= iepb_pkg::RST_EN;
        end else if (wr_en && hit(wr_addr, iepb_pkg::OFS_EN2)) begin
            en2_r <= merge(en2_r, wr_data, wr_strb, iepb_pkg::MASK_EN2); // RQ3 RQ4
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            en3_r <= iepb_pkg::RST_EN;
        end else if (wr_en && hit(wr_addr, iepb_pkg::OFS_EN3)) begin
            en3_r <= merge(en3_r, wr_data, wr_strb, iepb_pkg::MASK_EN3); // RQ5
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            en4_r <= iepb_pkg::RST_EN;
        end else if (wr_en && hit(wr_addr, iepb_pkg::OFS_EN4)) begin
            en4_r <= merge(en4_r, wr_data, wr_strb, iepb_pkg::MASK_EN4); // RQ6
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            en5_r <= iepb_pkg::RST_EN;
        end else if (wr_en && hit(wr_addr, iepb_pkg::OFS_EN5)) begin
            en5_r <= merge(en5_r, wr_data, wr_strb, iepb_pkg::MASK_EN5); // RQ7 RQ8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority registers
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            prio0_r <= iepb_pkg::RST_PRIO0;
        end else if (wr_en && hit(wr_addr, iepb_pkg::OFS_PRIO0)) begin
            prio0_r <= merge(prio0_r, wr_data, wr_strb, iepb_pkg::MASK_PRIO0); // RQ12
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            prio1_r <= iepb_pkg::RST_PRIO1;
        end else if (wr_en && hit(wr_addr, iepb_pkg::OFS_PRIO1)) begin
            prio1_r <= merge(prio1_r, wr_data, wr_strb, iepb_pkg::MASK_PRIO1); // RQ13
        end
    end

    // Level equals code; zero code blocks the source
    always_comb begin
        prio_lvl_ok[0] = field(prio0_r, iepb_pkg::FLD_PIN0) != 3'h0; // RQ9 RQ10 RQ11
        prio_lvl_ok[1] = field(prio0_r, iepb_pkg::FLD_CAPT) != 3'h0; // RQ11
        prio_lvl_ok[2] = field(prio0_r, iepb_pkg::FLD_COMP) != 3'h0; // RQ11
        prio_lvl_ok[3] = field(prio0_r, iepb_pkg::FLD_TIMER) != 3'h0; // RQ11
        prio_lvl_ok[4] = field(prio1_r, iepb_pkg::FLD_CAPT) != 3'h0; // RQ11
        prio_lvl_ok[5] = field(prio1_r, iepb_pkg::FLD_COMP) != 3'h0; // RQ11
        prio_lvl_ok[6] = field(prio1_r, iepb_pkg::FLD_TIMER) != 3'h0; // RQ11
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags, write one to clear
    assign clr2 = (wr_en && hit(wr_addr, iepb_pkg::OFS_FLAG2)) ? ones_hit(wr_data, wr_strb) : '0;
    assign clr3 = (wr_en && hit(wr_addr, iepb_pkg::OFS_FLAG3)) ? ones_hit(wr_data, wr_strb) : '0;
    assign clr4 = (wr_en && hit(wr_addr, iepb_pkg::OFS_FLAG4)) ? ones_hit(wr_data, wr_strb) : '0;
    assign clr5 = (wr_en && hit(wr_addr, iepb_pkg::OFS_FLAG5)) ? ones_hit(wr_data, wr_strb) : '0;
    assign clrp = (wr_en && hit(wr_addr, iepb_pkg::OFS_FLAGP)) ? ones_hit(wr_data, wr_strb) : '0;

    iepb_gate #(.W(16), .IMPL(iepb_pkg::MASK_EN2)) u_gate2 (
        .clk(MCLK), .rst_n(NRST), .req(SRC_REQ2), .clr(clr2), .en(en2_r),
        .prio_ok(16'hffff), .flag(flag2), .pend(PEND2)
    );
    iepb_gate #(.W(16), .IMPL(iepb_pkg::MASK_EN3)) u_gate3 (
        .clk(MCLK), .rst_n(NRST), .req(SRC_REQ3), .clr(clr3), .en(en3_r),
        .prio_ok(16'hffff), .flag(flag3), .pend(PEND3)
    );
    iepb_gate #(.W(16), .IMPL(iepb_pkg::MASK_EN4)) u_gate4 (
        .clk(MCLK), .rst_n(NRST), .req(SRC_REQ4), .clr(clr4), .en(en4_r),
        .prio_ok(16'hffff), .flag(flag4), .pend(PEND4)
    );
    iepb_gate #(.W(16), .IMPL(iepb_pkg::MASK_EN5)) u_gate5 (
        .clk(MCLK), .rst_n(NRST), .req(SRC_REQ5), .clr(clr5), .en(en5_r),
        .prio_ok(16'hffff), .flag(flag5), .pend(PEND5)
    );
    iepb_gate #(.W(7), .IMPL(iepb_pkg::MASK_FLAGP)) u_gatep (
        .clk(MCLK), .rst_n(NRST), .req(PRIO_SRC_REQ), .clr(clrp[6:0]), .en(PRIO_SRC_EN),
        .prio_ok(prio_lvl_ok), .flag(flagp), .pend(PEND_PRIO)
    );

    assign EN2 = en2_r;
    assign EN3 = en3_r;
    assign EN4 = en4_r;
    assign EN5 = en5_r;
    assign PRIO0 = prio0_r;
    assign PRIO1 = prio1_r;
    assign IRQ = |{PEND2, PEND3, PEND4, PEND5, PEND_PRIO}; // RQ16

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    chk_unimpl_zero: assert property ( // RQ2
        ((en2_r & ~iepb_pkg::MASK_EN2) == 16'h0000) && ((en5_r & ~iepb_pkg::MASK_EN5) == 16'h0000)
        && ((prio0_r & ~iepb_pkg::MASK_PRIO0) == 16'h0000)
    ) else $error("unimplemented enable or priority bit set");

    chk_prio1_low_zero: assert property ( // RQ13
        prio1_r[3:0] == 4'h0 && prio1_r[15] == 1'b0 && prio1_r[11] == 1'b0
    ) else $error("unimplemented priority group 1 bits set");

    chk_en_gates_pend: assert property ( // RQ1
        (PEND2 == (flag2 & en2_r)) && (PEND4 == (flag4 & en4_r))
    ) else $error("pending does not follow flag and enable");

    chk_flag_sets: assert property ( // RQ15
        (|(SRC_REQ3 & iepb_pkg::MASK_EN3))
        |=> ((flag3 & $past(SRC_REQ3) & iepb_pkg::MASK_EN3)
            == ($past(SRC_REQ3) & iepb_pkg::MASK_EN3))
    ) else $error("request did not set its flag");

    chk_zero_prio_block: assert property ( // RQ11
        (prio0_r[14:12] == 3'h0) |-> !PEND_PRIO[3]
    ) else $error("timer 1 pending with priority zero");

    chk_prio_pend: assert property ( // RQ16
        (flagp[6] && PRIO_SRC_EN[6] && prio1_r[14:12] != 3'h0) |-> PEND_PRIO[6]
    ) else $error("timer 2 not pending when fully qualified");

    chk_en3_write: assert property ( // RQ5
        (wr_en && wr_addr == iepb_pkg::OFS_EN3 && wr_strb[1:0] == 2'b11)
        |=> en3_r == ($past(wr_data[15:0]) & iepb_pkg::MASK_EN3)
    ) else $error("enable group 3 write not stored");

    chk_prio0_write: assert property ( // RQ12
        (wr_en && wr_addr == iepb_pkg::OFS_PRIO0 && wr_strb[1:0] == 2'b11)
        |=> prio0_r == ($past(wr_data[15:0]) & iepb_pkg::MASK_PRIO0)
    ) else $error("priority group 0 write not stored");

    chk_write_resp: assert property (
        wr_en |=> S_AXI_BVALID ##0 (S_AXI_BRESP == ($past(wr_ok) ? 2'b00 : 2'b10))
    ) else $error("write response missing or wrong");

    chk_read_resp: assert property (
        (S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID && $stable(S_AXI_RVALID) == 1'b0
    ) else $error("read data not returned one cycle after address");

    chk_irq_level: assert property ( // RQ16
        (|PEND5) |-> IRQ
    ) else $error("interrupt low while a source pends");

    chk_en2_write: assert property ( // RQ3 RQ4
        (wr_en && wr_addr == iepb_pkg::OFS_EN2 && wr_strb[1:0] == 2'b11)
        |=> en2_r == ($past(wr_data[15:0]) & iepb_pkg::MASK_EN2)
    ) else $error("enable group 2 write not stored");

    chk_en4_write: assert property ( // RQ6
        (wr_en && wr_addr == iepb_pkg::OFS_EN4 && wr_strb[1:0] == 2'b11)
        |=> en4_r == ($past(wr_data[15:0]) & iepb_pkg::MASK_EN4)
    ) else $error("enable group 4 write not stored");

    chk_en5_write: assert property ( // RQ7 RQ8
        (wr_en && wr_addr == iepb_pkg::OFS_EN5 && wr_strb[1:0] == 2'b11)
        |=> en5_r == ($past(wr_data[15:0]) & iepb_pkg::MASK_EN5)
    ) else $error("enable group 5 write not stored");

    chk_prio1_write: assert property ( // RQ13
        (wr_en && wr_addr == iepb_pkg::OFS_PRIO1 && wr_strb[1:0] == 2'b11)
        |=> prio1_r == ($past(wr_data[15:0]) & iepb_pkg::MASK_PRIO1)
    ) else $error("priority group 1 write not stored");

    chk_flag_clears: assert property ( // RQ15
        (clr2 != 16'h0000 && SRC_REQ2 == 16'h0000) |=> ((flag2 & $past(clr2)) == 16'h0000)
    ) else $error("written one did not clear its flag");

    chk_unimpl_en_zero: assert property ( // RQ2
        ((en3_r & ~iepb_pkg::MASK_EN3) == 16'h0000) && ((en4_r & ~iepb_pkg::MASK_EN4) == 16'h0000)
    ) else $error("unimplemented enable bit set in group 3 or 4");

    chk_pin0_prio_block: assert property ( // RQ11
        (prio0_r[2:0] == 3'h0) |-> !PEND_PRIO[0]
    ) else $error("pin 0 pending with priority zero");

endmodule : iepb_top
